// ### hdl/cbf_defines.svh
// constants for the breaker failure supervision stage
// assumes a 100 MHz clock and a plain strobe register port
//
// Operation
// - watch the selected primary trip signal and time its active period
// - assert backup trip once active time exceeds the operating delay
// - hold backup trip until the supervised primary trip releases
// - any stage driving the supervised output is covered
// - report blocked, start or trip; start/trip writable only when forced
// - cumulative start and trip counters, each clearable to zero
// - one force flag shared by all stages and output relays
// - force flag clears itself after five minutes
// - supervised output selector accepts one to fourteen
// - setting changes accepted only after password unlock
// - supervised output selection shared with breaker wear monitoring
// - keep the eight latest faults, oldest overwritten
// - each fault record holds date and millisecond time of day
// - each record holds elapsed delay in percent, 100 means trip
`ifndef CBF_DEFINES_SVH
`define CBF_DEFINES_SVH
`define CBF_CLK_NS          10
`define CBF_MS_NS           1000000
`define CBF_MS_CYCLES       (`CBF_MS_NS / `CBF_CLK_NS)
`define CBF_FORCE_MIN       5
`define CBF_FORCE_MS        (`CBF_FORCE_MIN * 60000)
`define CBF_RELAYS          14
`define CBF_LOG_DEPTH       8
`define CBF_PCT_TRIP        16'h0064
`define CBF_PASS_KEY        32'h00005A3C
`define CBF_RELAY_RST       4'h1
`define CBF_DELAY_RST       16'h0064
`define CBF_A_CTRL          8'h00
`define CBF_A_RELAY         8'h04
`define CBF_A_DELAY         8'h08
`define CBF_A_STATUS        8'h0C
`define CBF_A_SCNT          8'h10
`define CBF_A_TCNT          8'h14
`define CBF_A_PASS          8'h18
`define CBF_A_ISTAT         8'h1C
`define CBF_A_IMASK         8'h20
`define CBF_A_LSEL          8'h24
`define CBF_A_LDATE         8'h28
`define CBF_A_LTIME         8'h2C
`define CBF_A_LEDLY         8'h30
`define CBF_A_LCNT          8'h34
`define CBF_CTRL_FORCE      0
`define CBF_CTRL_BLOCK      1
`define CBF_EV_START        0
`define CBF_EV_TRIP         1
`define CBF_EV_FTMO         2
`define CBF_ST_IDLE         2'h0
`define CBF_ST_START        2'h1
`define CBF_ST_TRIP         2'h2
`define CBF_ST_BLOCKED      2'h3
`endif

// ### hdl/cbf_pkg.sv
// types for the breaker failure supervision stage
// assumes cbf_defines.svh is on the include path
package cbf_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } cbf_bus_t;

    typedef struct packed {
        logic [31:0] date;
        logic [31:0] timeMs;
        logic [15:0] elapsed_delay_pct;
    } cbf_rec_t;

    typedef enum logic [1:0] {
        CBF_IDLE,
        CBF_START,
        CBF_TRIP,
        CBF_BLOCKED
    } cbf_state_t;
endpackage : cbf_pkg

// ### hdl/cbf_breaker_failure_stage.sv
// breaker failure supervision stage with registers, irq and fault log
// assumes synchronous trip control inputs and a free running date/time
`timescale 1ns/100ps
`include "cbf_defines.svh"
module cbf_breaker_failure_stage #(
    parameter int MS_CYCLES = `CBF_MS_CYCLES,
    parameter int FORCE_MS  = `CBF_FORCE_MS
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire cbf_pkg::cbf_bus_t     bus,
    output logic [31:0]                regRdata,
    input  wire logic [13:0]           tripCtrl,
    input  wire logic                  blockIn,
    input  wire logic [31:0]           dateIn,
    input  wire logic [31:0]           timeMsIn,
    output logic                       backupTrip,
    output logic                       forceFlag,
    output logic [3:0]                 supervisedRelay,
    output logic [1:0]                 stageStatus,
    output logic                       irq
);
    import cbf_pkg::*;

    cbf_state_t  state;
    cbf_state_t  next_state;
    logic        ctrlBlock;
    logic        unlocked;
    logic [15:0] delayMs;
    logic [1:0]  forceSt;
    logic [31:0] startCount;
    logic [31:0] tripCount;
    logic [2:0]  irqStat;
    logic [2:0]  irqMask;
    logic [2:0]  logSel;
    logic [2:0]  wrPtr;
    logic [3:0]  logCount;
    logic [31:0] msPre;
    logic [15:0] elapsedMs;
    logic [31:0] freePre;
    logic [31:0] forceMs;
    cbf_rec_t    faultLog [`CBF_LOG_DEPTH];

    // register decode
    wire wrCtrl   = bus.wr && bus.addr == `CBF_A_CTRL;
    wire wrRelay  = bus.wr && bus.addr == `CBF_A_RELAY;
    wire wrDelay  = bus.wr && bus.addr == `CBF_A_DELAY;
    wire wrStatus = bus.wr && bus.addr == `CBF_A_STATUS;
    wire wrScnt   = bus.wr && bus.addr == `CBF_A_SCNT;
    wire wrTcnt   = bus.wr && bus.addr == `CBF_A_TCNT;
    wire wrPass   = bus.wr && bus.addr == `CBF_A_PASS;
    wire wrIstat  = bus.wr && bus.addr == `CBF_A_ISTAT;
    wire wrImask  = bus.wr && bus.addr == `CBF_A_IMASK;
    wire wrLsel   = bus.wr && bus.addr == `CBF_A_LSEL;

    // selector limited to the fitted relays; bad values keep the old one
    wire [3:0] relayNew = bus.wdata[3:0];
    wire relayOk  = relayNew != 4'h0 && relayNew <= 4'(`CBF_RELAYS);
    wire [3:0] relayIdx = supervisedRelay - 4'h1;
    wire supSig = tripCtrl[relayIdx];
    wire blocked = blockIn | ctrlBlock;
    wire forceOv = forceFlag && forceSt != `CBF_ST_IDLE;

    wire msTick   = msPre == 32'(MS_CYCLES - 1);
    wire freeTick = freePre == 32'(MS_CYCLES - 1);
    wire expired  = elapsedMs > delayMs;
    wire forceTmo = forceFlag && freeTick
                    && forceMs == 32'(FORCE_MS - 1);

    wire enterStart = state == CBF_IDLE && next_state == CBF_START;
    wire enterTrip  = state == CBF_START && next_state == CBF_TRIP;
    wire faultEnd   = (state == CBF_START || state == CBF_TRIP)
                      && next_state == CBF_IDLE;
    wire [2:0] irqEv = {forceTmo, enterTrip, enterStart};

    // elapsed delay in percent; divider is combinational, fine at 1 ms rate
    wire [22:0] pctNum = 23'(elapsedMs) * 23'h064;
    wire [22:0] pctDiv = pctNum / 23'(delayMs);
    wire [15:0] pctNow = (state == CBF_TRIP || delayMs == 16'h0000
                          || pctDiv >= 23'(`CBF_PCT_TRIP))
                         ? `CBF_PCT_TRIP : pctDiv[15:0];

    always_comb begin
        next_state = state;
        case (state)
            CBF_IDLE:    if (supSig) next_state = CBF_START;
            CBF_START: begin
                if (!supSig) next_state = CBF_IDLE;
                else if (expired) next_state = CBF_TRIP;
            end
            CBF_TRIP:    if (!supSig) next_state = CBF_IDLE;
            CBF_BLOCKED: next_state = CBF_IDLE;
            default:     next_state = CBF_IDLE;
        endcase
        if (blocked) next_state = CBF_BLOCKED;
    end

    always_ff @(posedge clk) begin
        if (rst) state <= CBF_IDLE;
        else state <= next_state;
    end

    // stage delay timer restarts at every start so it is exact to 1 ms
    // cleared on the blocking edge too, so no elapsed time shows in block
    always_ff @(posedge clk) begin
        if (rst || state != CBF_START || blocked) begin
            msPre     <= 32'h00000000;
            elapsedMs <= 16'h0000;
        end else begin
            msPre <= msTick ? 32'h00000000 : msPre + 32'h00000001;
            if (msTick && elapsedMs != 16'hFFFF)
                elapsedMs <= elapsedMs + 16'h0001;
        end
    end

    // free running ms tick for the force timeout
    always_ff @(posedge clk) begin
        if (rst) freePre <= 32'h00000000;
        else freePre <= freeTick ? 32'h00000000 : freePre + 32'h00000001;
    end

    always_ff @(posedge clk) begin
        if (rst || !forceFlag) forceMs <= 32'h00000000;
        else if (freeTick) forceMs <= forceMs + 32'h00000001;
    end

    // settings: only writes after unlock take effect
    always_ff @(posedge clk) begin
        if (rst) begin
            unlocked <= 1'b0;
        end else if (wrPass) begin
            unlocked <= bus.wdata == `CBF_PASS_KEY;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            forceFlag <= 1'b0;
            ctrlBlock <= 1'b0;
        end else if (forceTmo) begin
            forceFlag <= 1'b0;
        end else if (wrCtrl && unlocked) begin
            forceFlag <= bus.wdata[`CBF_CTRL_FORCE];
            ctrlBlock <= bus.wdata[`CBF_CTRL_BLOCK];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            supervisedRelay <= `CBF_RELAY_RST;
            delayMs         <= `CBF_DELAY_RST;
        end else if (unlocked) begin
            if (wrRelay && relayOk) supervisedRelay <= relayNew;
            if (wrDelay) delayMs <= bus.wdata[15:0];
        end
    end

    // forced status; only start or trip may be forced, dropped with flag
    always_ff @(posedge clk) begin
        if (rst || !forceFlag || forceTmo) begin
            forceSt <= `CBF_ST_IDLE;
        end else if (wrStatus) begin
            if (bus.wdata[1:0] == `CBF_ST_START
                || bus.wdata[1:0] == `CBF_ST_TRIP
                || bus.wdata[1:0] == `CBF_ST_IDLE)
                forceSt <= bus.wdata[1:0];
        end
    end

    // a clear in the same cycle as a count leaves the counter at one
    always_ff @(posedge clk) begin
        if (rst) begin
            startCount <= 32'h00000000;
            tripCount  <= 32'h00000000;
        end else begin
            if (enterStart)
                startCount <= (wrScnt ? 32'h00000000 : startCount)
                              + 32'h00000001;
            else if (wrScnt) startCount <= 32'h00000000;
            if (enterTrip)
                tripCount <= (wrTcnt ? 32'h00000000 : tripCount)
                             + 32'h00000001;
            else if (wrTcnt) tripCount <= 32'h00000000;
        end
    end

    // sticky events, write one to clear, a new event wins
    always_ff @(posedge clk) begin
        if (rst) begin
            irqStat <= 3'h0;
            irqMask <= 3'h0;
            logSel  <= 3'h0;
        end else begin
            irqStat <= (irqStat & ~(wrIstat ? bus.wdata[2:0] : 3'h0))
                       | irqEv;
            if (wrImask) irqMask <= bus.wdata[2:0];
            if (wrLsel) logSel <= bus.wdata[2:0];
        end
    end

    // fault log ring; a record is closed when the fault goes away
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr    <= 3'h0;
            logCount <= 4'h0;
        end else if (faultEnd) begin
            wrPtr <= wrPtr + 3'h1;
            if (logCount != 4'(`CBF_LOG_DEPTH))
                logCount <= logCount + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (faultEnd)
            faultLog[wrPtr] <= '{date: dateIn, timeMs: timeMsIn,
                                 elapsed_delay_pct: pctNow};
    end

    // index 0 of the selector is the newest record
    wire [2:0] rdIdx = wrPtr - 3'h1 - logSel;
    cbf_rec_t  rdRec;
    assign rdRec = faultLog[rdIdx];

    wire [1:0] stCode = forceOv ? forceSt
                      : state == CBF_START   ? `CBF_ST_START
                      : state == CBF_TRIP    ? `CBF_ST_TRIP
                      : state == CBF_BLOCKED ? `CBF_ST_BLOCKED
                      : `CBF_ST_IDLE;

    logic [31:0] rdMux;
    always_comb begin
        case (bus.addr)
            `CBF_A_CTRL:   rdMux = {30'h0, ctrlBlock, forceFlag};
            `CBF_A_RELAY:  rdMux = {28'h0, supervisedRelay};
            `CBF_A_DELAY:  rdMux = {16'h0, delayMs};
            `CBF_A_STATUS: rdMux = {30'h0, stCode};
            `CBF_A_SCNT:   rdMux = startCount;
            `CBF_A_TCNT:   rdMux = tripCount;
            `CBF_A_PASS:   rdMux = {31'h0, unlocked};
            `CBF_A_ISTAT:  rdMux = {29'h0, irqStat};
            `CBF_A_IMASK:  rdMux = {29'h0, irqMask};
            `CBF_A_LSEL:   rdMux = {29'h0, logSel};
            `CBF_A_LDATE:  rdMux = rdRec.date;
            `CBF_A_LTIME:  rdMux = rdRec.timeMs;
            `CBF_A_LEDLY:  rdMux = {16'h0, rdRec.elapsed_delay_pct};
            `CBF_A_LCNT:   rdMux = {28'h0, logCount};
            default:       rdMux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) regRdata <= 32'h00000000;
        else regRdata <= bus.rd ? rdMux : 32'h00000000;
    end

    // backup trip never asserts while blocked unless a test forces it
    assign backupTrip  = stCode == `CBF_ST_TRIP;
    assign stageStatus = stCode;
    assign irq         = |(irqStat & irqMask);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence sTimedOut;
        state == CBF_START && expired && supSig && !blocked;
    endsequence
    sequence sSigDrop;
        (state == CBF_TRIP || state == CBF_START) && !supSig && !blocked;
    endsequence

    a_trip_on_expiry: assert property (
        sTimedOut |=> state == CBF_TRIP ##0 backupTrip || forceOv)
        else $error("no trip after delay expiry");
    a_release_on_drop: assert property (
        sSigDrop ##0 !forceOv && !wrStatus
        |=> !backupTrip && state == CBF_IDLE)
        else $error("backup trip held after primary release");
    a_blocked_quiet: assert property (
        state == CBF_BLOCKED && !forceOv |-> !backupTrip
        && elapsedMs == 16'h0000)
        else $error("activity while blocked");
    a_start_count: assert property (
        enterStart && !wrScnt |=> startCount == $past(startCount) + 1)
        else $error("start counter missed a start");
    a_count_clear: assert property (
        wrTcnt && !enterTrip |=> tripCount == 32'h00000000)
        else $error("trip counter not cleared");
    a_force_timeout: assert property (
        forceTmo |=> !forceFlag && forceSt == `CBF_ST_IDLE)
        else $error("force flag survived its timeout");
    a_locked_delay: assert property (
        !unlocked |=> $stable(delayMs) && $stable(supervisedRelay))
        else $error("setting changed while locked");
    a_relay_range: assert property (
        supervisedRelay != 4'h0 && supervisedRelay <= 4'(`CBF_RELAYS))
        else $error("selector out of range");
    a_log_advance: assert property (
        faultEnd |=> wrPtr == $past(wrPtr) + 3'h1 ##1 $stable(wrPtr)
        || faultEnd)
        else $error("log pointer did not advance");
    a_status_force: assert property (
        !forceFlag |-> stCode == {state == CBF_BLOCKED || state == CBF_TRIP,
        state == CBF_BLOCKED || state == CBF_START})
        else $error("status does not follow stage");

endmodule : cbf_breaker_failure_stage

// ### testbench/cbf_trip_matrix.sv
// far-side model: two protection stages feeding the output relay matrix
// assumes stage trips and routes change right after rising clock edges
`timescale 1ns/100ps
module cbf_trip_matrix (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [1:0]  stageTrip,
    input  wire logic [3:0]  routeA,
    input  wire logic [3:0]  routeB,
    output logic      [13:0] tripCtrl
);
    // route 0 means unrouted; backup trip never enters this matrix
    logic [13:0] selA;
    logic [13:0] selB;
    logic [13:0] next_tripCtrl;
    assign selA = (stageTrip[0] && routeA != 4'h0) ?
                  (14'h0001 << (routeA - 4'h1)) : 14'h0000;
    assign selB = (stageTrip[1] && routeB != 4'h0) ?
                  (14'h0001 << (routeB - 4'h1)) : 14'h0000;
    // both stages may share one relay, the stage sees only the OR
    assign next_tripCtrl = selA | selB;
    always_ff @(posedge clk) begin
        if (rst) tripCtrl <= 14'h0000;
        else tripCtrl <= next_tripCtrl;
    end
endmodule : cbf_trip_matrix

// ### testbench/breaker_failure_backup_trip_bench.sv
// bench: lock checks, table of supervision cases, then log, counter, irq,
// block and force checks; assumes one ms shortened to ten clocks
`timescale 1ns/100ps
`include "cbf_defines.svh"
module breaker_failure_backup_trip_bench;
    import cbf_pkg::*;
    localparam int MS = 10;
    typedef struct {int relay; int stg; int src; int dly; int hold;} cbf_row_t;
    // relay, stage, routed relay, delay ms, hold ms
    cbf_row_t rows[6] = '{'{1, 0, 1, 2, 6}, '{14, 1, 14, 0, 4},
        '{7, 0, 7, 5, 2}, '{7, 0, 3, 1, 5}, '{2, 1, 2, 1, 1},
        '{9, 0, 9, 3, 8}};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    cbf_bus_t    bus = '0;
    logic [31:0] regRdata;
    logic [31:0] dateIn = '0;
    logic [31:0] timeMsIn = '0;
    logic [1:0]  stageTrip = 2'b00;
    logic [3:0]  routeA = 4'h0;
    logic [3:0]  routeB = 4'h0;
    logic [13:0] tripCtrl;
    logic        blockIn = 1'b0;
    logic        backupTrip;
    logic        forceFlag;
    logic [3:0]  supervisedRelay;
    logic [1:0]  stageStatus;
    logic        irq;
    int fails = 0, checks = 0, rec = 0, trips = 0, first, n;
    bit hit, tr;
    cbf_row_t r;
    always #5 clk = ~clk;
    cbf_trip_matrix cbf_trip_matrix_inst (.clk(clk), .rst(rst),
        .stageTrip(stageTrip), .routeA(routeA), .routeB(routeB),
        .tripCtrl(tripCtrl));
    cbf_breaker_failure_stage #(.MS_CYCLES(MS), .FORCE_MS(20))
        cbf_breaker_failure_stage_inst (.clk(clk), .rst(rst), .bus(bus),
        .regRdata(regRdata), .tripCtrl(tripCtrl), .blockIn(blockIn),
        .dateIn(dateIn), .timeMsIn(timeMsIn), .backupTrip(backupTrip),
        .forceFlag(forceFlag), .supervisedRelay(supervisedRelay),
        .stageStatus(stageStatus), .irq(irq));
    task automatic chk(input string nm, input logic [31:0] exp, got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // #1 at the end lets the write land before anyone looks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
        #1;
    endtask : wr
    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        chk(nm, exp, regRdata);
    endtask : rdchk
    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    initial begin
        #200000;
        fails++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("reset outs", 32'h8, {backupTrip, forceFlag, supervisedRelay,
            stageStatus, irq});
        rdchk("delay rst", `CBF_A_DELAY, `CBF_DELAY_RST);
        wr(`CBF_A_RELAY, 5);
        chk("locked", 1, supervisedRelay);
        wr(`CBF_A_PASS, `CBF_PASS_KEY);
        rdchk("unlock", `CBF_A_PASS, 1);
        wr(`CBF_A_RELAY, 0);
        wr(`CBF_A_RELAY, 15);
        chk("range", 1, supervisedRelay);
        for (int p = 0; p < 2; p++) begin
            foreach (rows[i]) begin
                r = rows[i];
                wr(`CBF_A_RELAY, r.relay);
                wr(`CBF_A_DELAY, r.dly);
                chk("relay", r.relay, supervisedRelay);
                @(posedge clk);
                routeA <= r.stg ? 4'h0 : 4'(r.src);
                routeB <= r.stg ? 4'(r.src) : 4'h0;
                stageTrip <= r.stg ? 2'b10 : 2'b01;
                dateIn <= rec;
                timeMsIn <= rec + 32'h1000;
                hit = (r.src == r.relay);
                tr = hit && r.hold > r.dly + 1;
                first = 0;
                for (int c = 1; c <= r.hold * MS; c++) begin
                    @(posedge clk);
                    #1;
                    if (c == 3) chk("start", hit, stageStatus);
                    if (backupTrip === 1'b1 && first == 0) first = c;
                end
                chk("backup", tr, backupTrip);
                if (tr) chk("trip time", 1, first >= r.dly * MS + 2 &&
                    first <= r.dly * MS + MS + 5);
                @(posedge clk);
                stageTrip <= 2'b00;
                repeat (3) @(posedge clk);
                #1;
                chk("release", 0, backupTrip);
                chk("idle", 0, stageStatus);
                if (hit) rec++;
                if (tr) trips++;
            end
        end
        rdchk("records", `CBF_A_LCNT, 8);
        wr(`CBF_A_LSEL, 0);
        rdchk("date", `CBF_A_LDATE, rec - 1);
        rdchk("time", `CBF_A_LTIME, rec - 1 + 32'h1000);
        rdchk("elapsed_delay_pct", `CBF_A_LEDLY, `CBF_PCT_TRIP);
        wr(`CBF_A_LSEL, 7);
        rdchk("oldest", `CBF_A_LDATE, rec - 8);
        rdchk("starts", `CBF_A_SCNT, rec);
        rdchk("trips", `CBF_A_TCNT, trips);
        wr(`CBF_A_SCNT, 0);
        wr(`CBF_A_TCNT, 0);
        rdchk("starts clr", `CBF_A_SCNT, 0);
        rdchk("trips clr", `CBF_A_TCNT, 0);
        rdchk("events", `CBF_A_ISTAT, 3);
        chk("irq masked", 0, irq);
        wr(`CBF_A_IMASK, 2);
        chk("irq", 1, irq);
        wr(`CBF_A_ISTAT, 3);
        chk("irq clr", 0, irq);
        // block raised on the same edge as the trip, which the matrix delays a clock, and dropped last so no stray start slips in
        @(posedge clk);
        blockIn <= 1'b1;
        stageTrip <= 2'b01;
        repeat (60) @(posedge clk);
        #1;
        chk("blocked", 3, stageStatus);
        chk("no backup", 0, backupTrip);
        @(posedge clk);
        stageTrip <= 2'b00;
        rdchk("no count", `CBF_A_SCNT, 0);
        @(posedge clk);
        blockIn <= 1'b0;
        wr(`CBF_A_CTRL, 2);
        // the block bit lands on the write edge, the state one edge later
        @(posedge clk);
        #1;
        chk("ctrl block", 3, stageStatus);
        wr(`CBF_A_CTRL, 0);
        wr(`CBF_A_STATUS, 2);
        chk("unforced", 0, stageStatus);
        wr(`CBF_A_CTRL, 1);
        chk("force", 1, forceFlag);
        wr(`CBF_A_STATUS, 1);
        chk("forced start", 1, stageStatus);
        wr(`CBF_A_STATUS, 2);
        chk("forced trip", 2, stageStatus);
        chk("forced backup", 1, backupTrip);
        n = 0;
        while (forceFlag === 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("force timeout", 1, n >= 170 && n <= 205);
        chk("after force", 0, stageStatus);
        wr(`CBF_A_IMASK, 4);
        chk("timeout irq", 1, irq);
        complete_run();
    end
endmodule : breaker_failure_backup_trip_bench
